// File: include/monitor_adc_regs.svh
// register offsets, field positions, reset values and timing counts of the monitor converter sequencer
`ifndef MONITOR_ADC_REGS_SVH
`define MONITOR_ADC_REGS_SVH

// byte offsets on the register bus
`define ADDR_W 9
`define REG_GENERAL_CONFIG 9'h000
`define REG_CONVERSION_TIME_CONFIG 9'h004
`define REG_AVERAGING_CONFIG 9'h008
`define REG_SEQUENCE_BOUNDS 9'h00C
`define REG_TRIGGER 9'h010
`define REG_GENERAL_STATUS 9'h014
`define REG_OVERRIDE_CODE 9'h018
`define REG_OVERRIDE_ENABLE 9'h01C
`define REG_TIME_BASE 9'h020
`define RESULT_PAGE 4'h2
`define SLOT_PAGE_BIT 8

// field positions
`define CFG_SHUNT_RANGE_BIT 0
`define CFG_AUTO_MODE_BIT 1
`define TRIG_BIT 0
`define OVERRIDE_EN_BIT 0
`define STAT_NOT_READY_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_SLOT_LSB 8
`define FIELD_W 3
`define FIELD_SENSE_LSB 0
`define FIELD_BUS_LSB 3
`define FIELD_TEMP_LSB 6
`define BOUND_START_LSB 0
`define BOUND_STOP_LSB 8
`define INDEX_W 6

// reset values
`define RST_GENERAL_CONFIG 2'h0
`define RST_FIELDS 9'h000
`define RST_BOUNDS 12'h000
`define RST_OVERRIDE_CODE 16'h0000
`define RST_SLOT_CODE 3'h0

// sizes
`define RESULT_W 16
`define ACC_W 26
`define PASS_W 11
`define TIMER_W 20
`define INPUT_COUNT 5
`define SLOT_COUNT 63
`define SLOT_LAST 6'h3E

// timing
`define CLOCK_PERIOD_NS 10
`define CONV_TIME_MIN_NS 52000
`define CONV_TIME_MAX_NS 4122000
`define CONV_CODE_LAST 7
// averaging shift per code, one nibble per code, code 0 lowest: 1,4,16,64,128,256,512,1024
`define AVG_SHIFT_TABLE 32'hA9876420

`endif

// File: include/monitor_adc_pkg.sv
// types shared by the monitor converter sequencer and its bench
package monitor_adc_pkg;

  typedef enum {st_idle, st_setup, st_convert} seq_state_t;

  typedef enum logic [2:0] {
    ch_ground = 3'h0,
    ch_first_shunt_sense = 3'h1,
    ch_second_shunt_sense = 3'h2,
    ch_first_high_voltage_input = 3'h3,
    ch_second_high_voltage_input = 3'h4,
    ch_die_temperature_input = 3'h5,
    ch_spare_a = 3'h6,
    ch_spare_b = 3'h7
  } slot_channel_code_t;

  // control toward the analog front end and filter
  typedef struct packed {
    logic active;
    logic shunt_range;
    slot_channel_code_t channel;
    logic sample_strobe;
  } front_end_ctrl_t;

endpackage

// File: hdl/monitor_adc_sequencer_control.sv
// sequencer, averaging and register file of the monitoring converter
`timescale 1ns/10ps
`include "monitor_adc_regs.svh"
module monitor_adc_sequencer_control #(
  parameter int unsigned CONV_CYCLES_MIN =
    (`CONV_TIME_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS,
  parameter int unsigned CONV_CYCLES_MAX = `CONV_TIME_MAX_NS / `CLOCK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [`RESULT_W-1:0] conversion_data,
  output monitor_adc_pkg::front_end_ctrl_t front_end
);

  // reset release through two flops
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // cycle count for a conversion time code, spread linearly over the range
  function automatic logic [`TIMER_W-1:0] conv_cycles(input logic [`FIELD_W-1:0] code);
    int unsigned span;
    span = CONV_CYCLES_MAX - CONV_CYCLES_MIN;
    return `TIMER_W'(CONV_CYCLES_MIN + (span * code) / `CONV_CODE_LAST);
  endfunction

  function automatic logic [3:0] avg_shift(input logic [`FIELD_W-1:0] code);
    logic [31:0] table_bits;
    table_bits = `AVG_SHIFT_TABLE;
    return table_bits[code*4 +: 4];
  endfunction

  // configuration and state registers
  logic [1:0] general_config;
  logic [8:0] conversion_time_config;
  logic [8:0] averaging_config;
  logic [11:0] sequence_bounds;
  logic [`RESULT_W-1:0] result_override_code;
  logic result_override_enable;
  logic [31:0] time_base;
  logic [2:0] sequence_slot_table [`SLOT_COUNT];
  monitor_adc_pkg::seq_state_t state;
  monitor_adc_pkg::seq_state_t next_state;
  logic [`INDEX_W-1:0] slot;
  logic [`INDEX_W-1:0] next_slot;
  logic [`PASS_W-1:0] pass;
  logic [`PASS_W-1:0] next_pass;
  logic [`TIMER_W-1:0] timer;
  logic [`TIMER_W-1:0] next_timer;
  logic [2:0] code;
  logic [2:0] next_code;
  logic not_ready;
  logic run_start;
  logic run_end;
  logic ack;

  // bus handshake: one wait cycle, then the access completes
  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  wire wr_fire = avs_write & ack;
  wire [`ADDR_W-1:0] addr = {avs_address[`ADDR_W-1:2], 2'b00};
  wire hit_general = addr == `REG_GENERAL_CONFIG;
  wire hit_time = addr == `REG_CONVERSION_TIME_CONFIG;
  wire hit_avg = addr == `REG_AVERAGING_CONFIG;
  wire hit_bounds = addr == `REG_SEQUENCE_BOUNDS;
  wire hit_trigger = addr == `REG_TRIGGER;
  wire hit_status = addr == `REG_GENERAL_STATUS;
  wire hit_ovr_code = addr == `REG_OVERRIDE_CODE;
  wire hit_ovr_en = addr == `REG_OVERRIDE_ENABLE;
  wire hit_time_base = addr == `REG_TIME_BASE;
  wire [2:0] result_sel = addr[4:2];
  wire hit_result = addr[8:5] == `RESULT_PAGE && result_sel < 3'(`INPUT_COUNT);
  wire [`INDEX_W-1:0] slot_sel = addr[7:2];
  wire hit_slot = addr[`SLOT_PAGE_BIT] && slot_sel <= `SLOT_LAST;
  wire trig_fire = wr_fire & hit_trigger & avs_byteenable[0] & avs_writedata[`TRIG_BIT];

  // decoded configuration
  wire auto_mode = general_config[`CFG_AUTO_MODE_BIT];
  // bounds kept packed as {stop, start}; the bus word spreads them to their lanes
  wire [`INDEX_W-1:0] start_raw = sequence_bounds[0 +: `INDEX_W];
  wire [`INDEX_W-1:0] stop_raw = sequence_bounds[`INDEX_W +: `INDEX_W];
  wire [31:0] bounds_word = {18'h0, stop_raw, 2'b00, start_raw};
  wire [`INDEX_W-1:0] seq_start = start_raw > `SLOT_LAST ? `SLOT_LAST : start_raw;
  wire [`INDEX_W-1:0] seq_stop = stop_raw > `SLOT_LAST ? `SLOT_LAST : stop_raw;
  wire [`INDEX_W-1:0] slot_after = slot == `SLOT_LAST ? '0 : slot + 6'h01;
  wire [3:0] sense_shift = avg_shift(averaging_config[`FIELD_SENSE_LSB +: `FIELD_W]);
  wire [3:0] bus_shift = avg_shift(averaging_config[`FIELD_BUS_LSB +: `FIELD_W]);
  wire [3:0] temp_shift = avg_shift(averaging_config[`FIELD_TEMP_LSB +: `FIELD_W]);
  wire [3:0] max_sb = sense_shift > bus_shift ? sense_shift : bus_shift;
  wire [3:0] max_shift = max_sb > temp_shift ? max_sb : temp_shift;
  wire [`PASS_W-1:0] pass_target = `PASS_W'(1) << max_shift;
  wire last_pass = (pass + 11'h001) == pass_target;

  // channel code of the slot being set up picks its time field
  wire [2:0] setup_code = sequence_slot_table[slot];
  wire setup_is_sense = setup_code == monitor_adc_pkg::ch_first_shunt_sense ||
    setup_code == monitor_adc_pkg::ch_second_shunt_sense;
  wire setup_is_temp = setup_code == monitor_adc_pkg::ch_die_temperature_input;
  // ground and spare codes use the bus time, they store nothing
  wire [`FIELD_W-1:0] setup_time_code = setup_is_sense ? conversion_time_config[`FIELD_SENSE_LSB +: `FIELD_W] :
    setup_is_temp ? conversion_time_config[`FIELD_TEMP_LSB +: `FIELD_W] :
    conversion_time_config[`FIELD_BUS_LSB +: `FIELD_W];

  // sample finishes when the timer runs out; an aborting trigger discards it
  wire sample_done = state == monitor_adc_pkg::st_convert && timer == '0 && !trig_fire;
  wire res_valid = code >= monitor_adc_pkg::ch_first_shunt_sense &&
    code <= monitor_adc_pkg::ch_die_temperature_input;
  wire [2:0] res_index = code - 3'h1;

  // sequencer next-state
  always_comb
  begin
    next_state = state;
    next_slot = slot;
    next_pass = pass;
    next_timer = timer;
    next_code = code;
    run_start = 1'b0;
    run_end = 1'b0;
    if (trig_fire)
    begin
      run_start = 1'b1;
      next_state = monitor_adc_pkg::st_setup;
      next_slot = seq_start;
      next_pass = '0;
    end
    else
    begin
      unique case (state)
        monitor_adc_pkg::st_idle:
        begin
          if (auto_mode)
          begin
            run_start = 1'b1;
            next_state = monitor_adc_pkg::st_setup;
            next_slot = seq_start;
            next_pass = '0;
          end
        end
        monitor_adc_pkg::st_setup:
        begin
          next_code = setup_code;
          next_timer = conv_cycles(setup_time_code) - 20'h00001;
          next_state = monitor_adc_pkg::st_convert;
        end
        monitor_adc_pkg::st_convert:
        begin
          if (timer != '0)
            next_timer = timer - 20'h00001;
          else if (slot != seq_stop)
          begin
            next_slot = slot_after;
            next_state = monitor_adc_pkg::st_setup;
          end
          else if (!last_pass)
          begin
            next_pass = pass + 11'h001;
            next_slot = seq_start;
            next_state = monitor_adc_pkg::st_setup;
          end
          else
          begin
            run_end = 1'b1;
            if (auto_mode)
            begin
              run_start = 1'b1;
              next_slot = seq_start;
              next_pass = '0;
              next_state = monitor_adc_pkg::st_setup;
            end
            else
              next_state = monitor_adc_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // a new run start wins over the end of the old one
  wire next_not_ready = run_start ? 1'b1 : run_end ? 1'b0 : not_ready;

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state <= monitor_adc_pkg::st_idle;
      slot <= '0;
      pass <= '0;
      timer <= '0;
      code <= `RST_SLOT_CODE;
      not_ready <= 1'b0;
      time_base <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      slot <= next_slot;
      pass <= next_pass;
      timer <= next_timer;
      code <= next_code;
      not_ready <= next_not_ready;
      time_base <= time_base + 32'h00000001;
    end
  end

  // per-input accumulation and result registers
  wire [`INPUT_COUNT*`RESULT_W-1:0] result_flat;
  for (genvar g = 0; g < `INPUT_COUNT; g++)
  begin : g_input
    localparam bit IS_SHUNT = g < 2;
    logic [`ACC_W-1:0] acc;
    logic [`PASS_W-1:0] cnt;
    logic [`RESULT_W-1:0] result;
    wire [3:0] shift = g < 2 ? sense_shift : g < 4 ? bus_shift : temp_shift;
    wire hit = sample_done & res_valid & (res_index == 3'(g));
    // shunt samples are signed, the rest unsigned
    wire [`ACC_W-1:0] ext = IS_SHUNT ? {{10{conversion_data[15]}}, conversion_data} : {10'h000, conversion_data};
    wire [`ACC_W-1:0] sum = acc + ext;
    wire full = (cnt + 11'h001) == (`PASS_W'(1) << shift);
    wire [`ACC_W-1:0] avg = IS_SHUNT ? `ACC_W'($signed(sum) >>> shift) : sum >> shift;
    wire [`ACC_W-1:0] next_acc = run_start ? '0 : hit ? (full ? '0 : sum) : acc;
    wire [`PASS_W-1:0] next_cnt = run_start ? '0 : hit ? (full ? '0 : cnt + 11'h001) : cnt;
    // override beats conversion data; otherwise only a finished average lands
    wire [`RESULT_W-1:0] next_result = result_override_enable ? result_override_code :
      (hit & full) ? avg[`RESULT_W-1:0] : result;
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
      if (!rst_sync_b)
      begin
        acc <= '0;
        cnt <= '0;
        result <= '0;
      end
      else
      begin
        acc <= next_acc;
        cnt <= next_cnt;
        result <= next_result;
      end
    end
    assign result_flat[g*`RESULT_W +: `RESULT_W] = result;
  end

  // software-written configuration
  wire [31:0] wd_general = merge({30'h0, general_config}, avs_writedata, avs_byteenable);
  wire [31:0] wd_time = merge({23'h0, conversion_time_config}, avs_writedata, avs_byteenable);
  wire [31:0] wd_avg = merge({23'h0, averaging_config}, avs_writedata, avs_byteenable);
  wire [31:0] wd_bounds = merge(bounds_word, avs_writedata, avs_byteenable);
  wire [31:0] wd_ovr = merge({16'h0, result_override_code}, avs_writedata, avs_byteenable);
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      general_config <= `RST_GENERAL_CONFIG;
      conversion_time_config <= `RST_FIELDS;
      averaging_config <= `RST_FIELDS;
      sequence_bounds <= `RST_BOUNDS;
      result_override_code <= `RST_OVERRIDE_CODE;
      result_override_enable <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (hit_general)
        general_config <= wd_general[1:0];
      if (hit_time)
        conversion_time_config <= wd_time[8:0];
      if (hit_avg)
        averaging_config <= wd_avg[8:0];
      if (hit_bounds)
        sequence_bounds <= {wd_bounds[`BOUND_STOP_LSB +: `INDEX_W], wd_bounds[`BOUND_START_LSB +: `INDEX_W]};
      if (hit_ovr_code)
        result_override_code <= wd_ovr[15:0];
      if (hit_ovr_en && avs_byteenable[0])
        result_override_enable <= avs_writedata[`OVERRIDE_EN_BIT];
    end
  end

  // slot table, one channel code per slot
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      for (int i = 0; i < `SLOT_COUNT; i++)
        sequence_slot_table[i] <= `RST_SLOT_CODE;
    end
    else if (wr_fire && hit_slot && avs_byteenable[0])
      sequence_slot_table[slot_sel] <= avs_writedata[2:0];
  end

  // read-back selection; reads have no side effects on the sequencer
  wire [31:0] general_status_word = {18'h0, slot, 6'h00,
    state != monitor_adc_pkg::st_idle, not_ready};
  wire [31:0] rd_mux =
    hit_general ? {30'h0, general_config} :
    hit_time ? {23'h0, conversion_time_config} :
    hit_avg ? {23'h0, averaging_config} :
    hit_bounds ? bounds_word :
    hit_status ? general_status_word :
    hit_ovr_code ? {16'h0, result_override_code} :
    hit_ovr_en ? {31'h0, result_override_enable} :
    hit_time_base ? time_base :
    hit_result ? {16'h0, result_flat[result_sel*`RESULT_W +: `RESULT_W]} :
    hit_slot ? {29'h0, sequence_slot_table[slot_sel]} :
    32'h00000000;

  // front-end control from flops, one cycle behind the sequencer
  wire monitor_adc_pkg::front_end_ctrl_t next_front_end = '{
    active: state != monitor_adc_pkg::st_idle,
    shunt_range: general_config[`CFG_SHUNT_RANGE_BIT],
    channel: monitor_adc_pkg::slot_channel_code_t'(code),
    sample_strobe: sample_done};

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      front_end <= '0;
    end
    else
    begin
      ack <= bus_req & ~ack;
      if (avs_read && !ack)
        avs_readdata <= rd_mux;
      front_end <= next_front_end;
    end
  end

endmodule

// File: verif/monitor_adc_sequencer_checker.sv
// port assertions for the monitor converter sequencer
`timescale 1ns/10ps
`include "monitor_adc_regs.svh"
module monitor_adc_sequencer_checker #(
  parameter int unsigned CONV_CYCLES_MIN = 4,
  parameter int unsigned CONV_CYCLES_MAX = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire monitor_adc_pkg::front_end_ctrl_t front_end
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // a completed read, and an accepted trigger write
  sequence read_done;
    avs_read && !avs_waitrequest;
  endsequence
  sequence trigger_done;
    avs_write && !avs_waitrequest && avs_address == `REG_TRIGGER && avs_byteenable[0] && avs_writedata[0];
  endsequence
  a_wait_first_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state in first request cycle");
  a_wait_one_state: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  a_readdata_holds: assert property ($changed(avs_readdata) |-> read_done)
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (read_done ##0 avs_address == 9'h1FC |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_trigger_reads_zero: assert property (read_done ##0 avs_address == `REG_TRIGGER |-> avs_readdata == 32'h0)
    else $error("trigger register read not zero");
  a_trigger_starts_run: assert property (trigger_done |-> ##[1:3] front_end.active)
    else $error("trigger did not start a run");
  a_strobe_spacing: assert property (front_end.sample_strobe |=> !front_end.sample_strobe [*4])
    else $error("samples closer than one conversion");
  a_strobe_in_run: assert property (front_end.sample_strobe |-> $past(front_end.active))
    else $error("sample strobe outside a run");
endmodule
bind monitor_adc_sequencer_control monitor_adc_sequencer_checker #(
  .CONV_CYCLES_MIN(CONV_CYCLES_MIN),
  .CONV_CYCLES_MAX(CONV_CYCLES_MAX)
) checker_i (
  .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .front_end(front_end)
);

// File: verif/test_monitor_adc_sequencer_control.sv
// self-checking bench of the monitor converter sequencer
`timescale 1ns/10ps
`include "monitor_adc_regs.svh"
module test_monitor_adc_sequencer_control;
  localparam int CMIN = 4;
  localparam int CMAX = 32;
  localparam logic [8:0] ZERO_A [14] = '{9'h000, 9'h004, 9'h008, 9'h00C, 9'h010, 9'h014, 9'h018, 9'h01C,
    9'h040, 9'h048, 9'h050, 9'h100, 9'h1F8, 9'h1FC};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [`ADDR_W-1:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [`RESULT_W-1:0] conversion_data = 16'h0000;
  monitor_adc_pkg::front_end_ctrl_t front_end;
  logic cfg_range = 1'b0;
  logic [31:0] rd;
  logic [31:0] d;
  logic [15:0] samp [8] = '{default: 16'h0000};
  logic [15:0] exp_res [8] = '{default: 16'h0000};
  logic [2:0] slot_m [63] = '{default: 3'h0};
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int act_n = 0;
  int str_n = 0;
  int i;
  int n;

  monitor_adc_sequencer_control #(.CONV_CYCLES_MIN(CMIN), .CONV_CYCLES_MAX(CMAX)) dut (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conversion_data(conversion_data), .front_end(front_end)
  );

  // verdict and end of run
  task automatic results;
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) err_count++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // polls status until the run is over; polling doubles as reads during conversion
  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      bus(1'b0, `REG_GENERAL_STATUS, 32'h0);
      k++;
    end
    while (rd[1:0] !== 2'h0 && k < 3000);
    if (k >= 3000) err_count++;
  endtask

  function automatic int cyc(input logic [2:0] code);
    return CMIN + (CMAX - CMIN) * code / 7;
  endfunction

  // shunt slots time with the shunt field, temperature with its own, the rest with the bus field
  function automatic logic [2:0] field_of(input logic [2:0] ch, input logic [8:0] tf);
    case (ch)
      3'h1, 3'h2: return tf[2:0];
      3'h5: return tf[8:6];
      default: return tf[5:3];
    endcase
  endfunction

  // one triggered run over start..stop; avg selects four passes
  task automatic run(input int start, input int stop, input logic [8:0] tf, input bit avg);
    logic [15:0] nxt [8];
    int ec, k, p;
    nxt = exp_res;
    ec = 0;
    k = start;
    p = avg ? 4 : 1;
    forever
    begin
      ec += 1 + cyc(field_of(slot_m[k], tf));
      if (slot_m[k] >= 3'h1 && slot_m[k] <= 3'h5) nxt[slot_m[k]] = samp[slot_m[k]];
      if (k == stop) break;
      k = (k == 62) ? 0 : k + 1;
    end
    bus(1'b1, `REG_CONVERSION_TIME_CONFIG, {23'h0, tf});
    bus(1'b1, `REG_SEQUENCE_BOUNDS, {18'h0, stop[5:0], 2'h0, start[5:0]});
    act_n = 0;
    str_n = 0;
    bus(1'b1, `REG_TRIGGER, 32'h1);
    bus(1'b0, `REG_GENERAL_STATUS, 32'h0);
    check(32'(rd[0]), 32'h1);
    check(32'(front_end.shunt_range), 32'(cfg_range));
    k = 0;
    while (avg && str_n < 6 && k < 1000)
    begin
      @(posedge clock);
      k++;
    end
    if (avg) rdc(9'h040, {16'h0, exp_res[1]});
    wait_idle();
    check(act_n, p * ec);
    exp_res = nxt;
    for (k = 1; k < 6; k++) rdc(9'(9'h03C + 4 * k), {16'h0, exp_res[k]});
  endtask

  always #5 clock = ~clock;

  // front end stand-in, activity counters and hang limit
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    conversion_data <= samp[front_end.channel];
    if (front_end.active === 1'b1) act_n <= act_n + 1;
    if (front_end.sample_strobe === 1'b1) str_n <= str_n + 1;
    if (cycles == 60000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    void'($urandom(11));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b1, 9'h1FC, 32'hFFFFFFFF);
    foreach (ZERO_A[k]) rdc(ZERO_A[k], 32'h0);
    // back-to-back reads capture the time count three cycles apart
    bus(1'b0, `REG_TIME_BASE, 32'h0);
    d = rd;
    rdc(`REG_TIME_BASE, d + 32'h3);
    // random slot codes and field values read back
    repeat (8)
    begin
      i = $urandom_range(62);
      slot_m[i] = 3'($urandom);
      bus(1'b1, 9'(9'h100 + 4 * i), {29'h0, slot_m[i]});
      rdc(9'(9'h100 + 4 * i), {29'h0, slot_m[i]});
      d = $urandom & 32'h1FF;
      bus(1'b1, 9'(9'h004 + 4 * (i % 2)), d);
      rdc(9'(9'h004 + 4 * (i % 2)), d);
    end
    bus(1'b1, `REG_AVERAGING_CONFIG, 32'h0);
    for (i = 0; i < 5; i++)
    begin
      slot_m[i] = 3'(i + 1);
      bus(1'b1, 9'(9'h100 + 4 * i), i + 1);
    end
    // direct runs with random timing and range, a single-slot corner, then a four-pass averaging run
    repeat (3)
    begin
      cfg_range = 1'($urandom);
      bus(1'b1, `REG_GENERAL_CONFIG, {31'h0, cfg_range});
      for (i = 1; i < 6; i++) samp[i] = 16'($urandom);
      run(0, 4, 9'($urandom), 1'b0);
    end
    run(4, 4, 9'h1FF, 1'b0);
    bus(1'b1, `REG_AVERAGING_CONFIG, 32'h49);
    for (i = 1; i < 6; i++) samp[i] = 16'($urandom);
    run(0, 4, 9'h000, 1'b1);
    bus(1'b1, `REG_AVERAGING_CONFIG, 32'h0);
    // override code replaces every result
    d = $urandom & 32'hFFFF;
    bus(1'b1, `REG_OVERRIDE_CODE, d);
    bus(1'b1, `REG_OVERRIDE_ENABLE, 32'h1);
    for (i = 1; i < 6; i++) rdc(9'(9'h03C + 4 * i), d);
    bus(1'b1, `REG_OVERRIDE_ENABLE, 32'h0);
    // auto mode loops, trigger restarts, then back to direct
    bus(1'b1, `REG_SEQUENCE_BOUNDS, 32'h0400);
    str_n = 0;
    bus(1'b1, `REG_GENERAL_CONFIG, 32'h2);
    n = 0;
    while (str_n < 12 && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(str_n >= 12), 32'h1);
    bus(1'b1, `REG_TRIGGER, 32'h1);
    bus(1'b0, `REG_GENERAL_STATUS, 32'h0);
    check(32'(rd[0]), 32'h1);
    bus(1'b1, `REG_GENERAL_CONFIG, 32'h0);
    wait_idle();
    for (i = 1; i < 6; i++) rdc(9'(9'h03C + 4 * i), {16'h0, samp[i]});
    exp_res = samp;
    // wrapping bounds with spare codes in the list
    slot_m[61] = 3'h7;
    slot_m[62] = 3'h6;
    slot_m[1] = 3'h5;
    bus(1'b1, 9'h1F4, 32'h7);
    bus(1'b1, 9'h1F8, 32'h6);
    bus(1'b1, 9'h104, 32'h5);
    for (i = 1; i < 6; i++) samp[i] = 16'($urandom);
    run(61, 1, 9'($urandom), 1'b0);
    results();
  end
endmodule
